// ==== ausu_regs.svh ====
`ifndef AUSU_REGS_SVH
`define AUSU_REGS_SVH
// byte addresses on the apb bus
`define AUSU_OFF_MAP0 12'h000
`define AUSU_OFF_MAP1 12'h004
`define AUSU_OFF_MAP2 12'h008
`define AUSU_OFF_SSC 12'h00C
`define AUSU_OFF_DHI 12'h010
`define AUSU_OFF_DLO 12'h014
`define AUSU_OFF_IRCFG 12'h018
// secondary status/control fields
`define AUSU_SSC_MAP_BIT 7
`define AUSU_SSC_TXINV_BIT 4
`define AUSU_SSC_RXINV_BIT 3
`define AUSU_SSC_LBRK_BIT 2
`define AUSU_SSC_DIR_BIT 1
`define AUSU_SSC_RAF_BIT 0
`define AUSU_SSC_WMASK 8'h9E
// data high fields
`define AUSU_DHI_RX9_BIT 7
`define AUSU_DHI_TX9_BIT 6
// primary control one fields
`define AUSU_CR1_LOOP_BIT 7
`define AUSU_CR1_SWIRE_BIT 5
`define AUSU_CR1_NINE_BIT 4
// infrared config fields
`define AUSU_IR_EN_BIT 2
// reset values
`define AUSU_SSC_RST 8'h00
`define AUSU_BAUD_RST 13'h0004
`define AUSU_CR1_RST 8'h00
// frame and break lengths in bit times, and x16 slots per bit
`define AUSU_IDLE8 4'hA
`define AUSU_IDLE9 4'hB
`define AUSU_BRK_SHORT 4'hA
`define AUSU_BRK_LONG 4'hD
`define AUSU_SLOTS 5'h10
`endif

// ==== ausu_pkg.sv ====
package ausu_pkg;
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_SHIFT = 2'b01,
        TX_BREAK = 2'b10
    } ausu_tx_state_type;

    typedef enum logic [1:0] {
        RX_SEARCH = 2'b00,
        RX_SHIFT = 2'b01,
        RX_DONE = 2'b10
    } ausu_rx_state_type;

    typedef enum logic [1:0] {
        IR_W3_16 = 2'b00,
        IR_W1_16 = 2'b01,
        IR_W1_32 = 2'b10,
        IR_W1_4 = 2'b11
    } ausu_ir_width_type;

    typedef struct packed {
        logic [7:0] ssc;
        logic [12:0] baud;
        logic [7:0] cr1;
        logic [7:0] acr1;
        logic [7:0] acr2;
        logic [2:0] ircfg;
        logic tx9;
        logic [7:0] txbuf;
        logic txfull;
        logic brk_req;
        logic [8:0] rxbuf;
        logic [12:0] bcnt;
        logic x16;
        logic x32;
        logic ph32;
        ausu_tx_state_type tst;
        logic [10:0] tsh;
        logic [3:0] tbits;
        logic [4:0] tslot;
        logic tbit;
        logic ir_en_l;
        ausu_ir_width_type ir_w_l;
        ausu_rx_state_type rst_;
        logic [3:0] rslot;
        logic [3:0] rbits;
        logic [9:0] rsh;
        logic [3:0] ones;
        logic rx_stretch;
        logic [4:0] rx_hold;
        logic txd_o;
        logic txd_oe;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } ausu_state_type;
endpackage

// ==== ausu_top.sv ====
`timescale 1ns/10ps
`include "ausu_regs.svh"
module ausu_top #(
    parameter int BAUD_W = 13
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // line side
    input wire logic rxd_i,
    input wire logic txd_i,
    output logic txd_o,
    output logic txd_oe
);
    ausu_pkg::ausu_state_type q_ff;
    ausu_pkg::ausu_state_type nxt_q;

    // address decode, used for both reads and writes
    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = (a == off);
    endfunction

    // any aligned offset up to the infrared config word
    function automatic logic mapped(input logic [11:0] a);
        mapped = (a[1:0] == 2'h0) && (a <= `AUSU_OFF_IRCFG);
    endfunction

    // pulse length in x32 ticks for each width; the start slot is derived from it
    function automatic logic [4:0] ir_len(input ausu_pkg::ausu_ir_width_type w);
        case (w)
            ausu_pkg::IR_W3_16: ir_len = 5'h06;
            ausu_pkg::IR_W1_16: ir_len = 5'h02;
            ausu_pkg::IR_W1_32: ir_len = 5'h01;
            ausu_pkg::IR_W1_4: ir_len = 5'h08;
            default: ir_len = 5'h06;
        endcase
    endfunction

    logic acc;
    logic wr;
    logic rd;
    logic alternate_map_select;
    logic rx_raw;
    logic rx_bit;
    logic nine;
    logic tx_line;
    logic [4:0] plen;
    logic [4:0] pstart;
    logic [9:0] rcv;
    assign acc = psel && penable;
    assign wr = acc && pwrite;
    assign rd = acc && !pwrite;
    assign alternate_map_select = q_ff.ssc[`AUSU_SSC_MAP_BIT];
    assign nine = q_ff.cr1[`AUSU_CR1_NINE_BIT];
    assign rx_raw = (q_ff.cr1[`AUSU_CR1_SWIRE_BIT] ? txd_i : rxd_i) ^ q_ff.ssc[`AUSU_SSC_RXINV_BIT];
    assign rx_bit = q_ff.ircfg[`AUSU_IR_EN_BIT] ? !q_ff.rx_stretch : rx_raw;
    assign plen = ir_len(q_ff.ir_w_l);
    assign pstart = 5'h10 - {1'b0, plen[4:1]};
    assign rcv = {rx_bit, q_ff.rsh[9:1]};

    always_comb
    begin
        nxt_q = q_ff;
        nxt_q.pready = 1'b0;
        nxt_q.pslverr = 1'b0;
        nxt_q.prdata = 32'h00000000;
        // shared baud generator: x32 tick, x16 every other
        nxt_q.x32 = 1'b0;
        nxt_q.x16 = 1'b0;
        if (q_ff.baud != 13'h0000)
        begin
            if (q_ff.bcnt >= {1'b0, q_ff.baud[12:1]} || q_ff.baud[12:1] == 12'h000)
            begin
                nxt_q.bcnt = 13'h0001;
                nxt_q.x32 = 1'b1;
                nxt_q.ph32 = !q_ff.ph32;
                nxt_q.x16 = q_ff.ph32;
            end
            else
            begin
                nxt_q.bcnt = q_ff.bcnt + 13'h0001;
            end
        end
        // apb answer after one wait state; a write lands at the pready edge
        if (acc && !q_ff.pready)
        begin
            nxt_q.pready = 1'b1;
            if (wr)
                nxt_q.pslverr = !mapped(paddr);
            else
            begin
                if (hit(paddr, `AUSU_OFF_MAP0))
                    nxt_q.prdata = alternate_map_select ? 32'h00000000 : {27'h0, q_ff.baud[12:8]};
                else if (hit(paddr, `AUSU_OFF_MAP1))
                    nxt_q.prdata = {24'h0, alternate_map_select ? q_ff.acr1 : q_ff.baud[7:0]};
                else if (hit(paddr, `AUSU_OFF_MAP2))
                    nxt_q.prdata = {24'h0, alternate_map_select ? q_ff.acr2 : q_ff.cr1};
                else if (hit(paddr, `AUSU_OFF_SSC))
                    nxt_q.prdata = {24'h0, q_ff.ssc};
                else if (hit(paddr, `AUSU_OFF_DHI))
                    nxt_q.prdata = {24'h0, q_ff.rxbuf[8], q_ff.tx9, 6'h00};
                else if (hit(paddr, `AUSU_OFF_DLO))
                    nxt_q.prdata = {24'h0, q_ff.rxbuf[7:0]};
                else if (hit(paddr, `AUSU_OFF_IRCFG))
                    nxt_q.prdata = {28'h0, q_ff.brk_req, q_ff.ircfg};
                else
                    nxt_q.pslverr = 1'b1;
            end
        end
        // write effect in the cycle pready stands
        if (wr && q_ff.pready)
        begin
            if (hit(paddr, `AUSU_OFF_MAP0))
            begin
                if (!alternate_map_select)
                    nxt_q.baud[12:8] = pwdata[4:0];
            end
            else if (hit(paddr, `AUSU_OFF_MAP1))
            begin
                if (alternate_map_select)
                    nxt_q.acr1 = pwdata[7:0];
                else
                    nxt_q.baud[7:0] = pwdata[7:0];
            end
            else if (hit(paddr, `AUSU_OFF_MAP2))
            begin
                if (alternate_map_select)
                    nxt_q.acr2 = pwdata[7:0];
                else
                    nxt_q.cr1 = pwdata[7:0];
            end
            else if (hit(paddr, `AUSU_OFF_SSC))
                nxt_q.ssc = (pwdata[7:0] & `AUSU_SSC_WMASK) | (q_ff.ssc & ~`AUSU_SSC_WMASK);
            else if (hit(paddr, `AUSU_OFF_DHI))
                nxt_q.tx9 = pwdata[`AUSU_DHI_TX9_BIT];
            else if (hit(paddr, `AUSU_OFF_DLO))
            begin
                nxt_q.txbuf = pwdata[7:0];
                nxt_q.txfull = 1'b1;
            end
            else if (hit(paddr, `AUSU_OFF_IRCFG))
            begin
                nxt_q.ircfg = pwdata[2:0];
                nxt_q.brk_req = pwdata[3];
            end
        end
        // transmitter on x32 slots (32 per bit), infrared edges on x32
        if (q_ff.x32)
        begin
            nxt_q.tslot = q_ff.tslot + 5'h01;
            if (q_ff.tslot == 5'h1F)
            begin
                nxt_q.tslot = 5'h00;
                nxt_q.ir_en_l = q_ff.ircfg[`AUSU_IR_EN_BIT];
                nxt_q.ir_w_l = ausu_pkg::ausu_ir_width_type'(q_ff.ircfg[1:0]);
                case (q_ff.tst)
                    ausu_pkg::TX_IDLE:
                    begin
                        nxt_q.tbit = 1'b1;
                        if (q_ff.brk_req)
                        begin
                            nxt_q.tst = ausu_pkg::TX_BREAK;
                            nxt_q.tbits = q_ff.ssc[`AUSU_SSC_LBRK_BIT] ? `AUSU_BRK_LONG : `AUSU_BRK_SHORT;
                            nxt_q.brk_req = 1'b0;
                            nxt_q.tbit = 1'b0;
                        end
                        else if (q_ff.txfull)
                        begin
                            nxt_q.tst = ausu_pkg::TX_SHIFT;
                            nxt_q.tsh = {1'b1, q_ff.tx9, q_ff.txbuf, 1'b0};
                            nxt_q.tbits = nine ? `AUSU_IDLE9 : `AUSU_IDLE8;
                            nxt_q.txfull = 1'b0;
                            nxt_q.tbit = 1'b0;
                        end
                    end
                    ausu_pkg::TX_SHIFT:
                    begin
                        nxt_q.tsh = {1'b1, q_ff.tsh[10:1]};
                        nxt_q.tbits = q_ff.tbits - 4'h1;
                        nxt_q.tbit = nine ? q_ff.tsh[1] : (q_ff.tbits == 4'h2 ? 1'b1 : q_ff.tsh[1]);
                        if (q_ff.tbits == 4'h1)
                        begin
                            nxt_q.tst = ausu_pkg::TX_IDLE;
                            nxt_q.tbit = 1'b1;
                        end
                    end
                    ausu_pkg::TX_BREAK:
                    begin
                        nxt_q.tbits = q_ff.tbits - 4'h1;
                        if (q_ff.tbits == 4'h1)
                        begin
                            nxt_q.tst = ausu_pkg::TX_IDLE;
                            nxt_q.tbit = 1'b1;
                        end
                    end
                    default: nxt_q.tst = ausu_pkg::TX_IDLE;
                endcase
            end
        end
        // line encode: nrz or centred infrared pulse
        if (q_ff.ir_en_l)
            tx_line = !(!q_ff.tbit && q_ff.tslot >= pstart && q_ff.tslot < pstart + plen);
        else
            tx_line = q_ff.tbit;
        if (q_ff.ir_en_l)
            nxt_q.txd_o = !tx_line ^ q_ff.ssc[`AUSU_SSC_TXINV_BIT];
        else
            nxt_q.txd_o = tx_line ^ q_ff.ssc[`AUSU_SSC_TXINV_BIT];
        nxt_q.txd_oe = !q_ff.cr1[`AUSU_CR1_SWIRE_BIT] || q_ff.ssc[`AUSU_SSC_DIR_BIT];
        // infrared decoder stretches a pulse to one bit on x16
        if (q_ff.x16)
        begin
            if (rx_raw)
            begin
                nxt_q.rx_stretch = 1'b1;
                nxt_q.rx_hold = `AUSU_SLOTS;
            end
            else if (q_ff.rx_hold != 5'h00)
                nxt_q.rx_hold = q_ff.rx_hold - 5'h01;
            else
                nxt_q.rx_stretch = 1'b0;
            // receiver, independent of transmitter
            // ones counted per bit time, any zero restarts the count
            if (!rx_bit)
                nxt_q.ones = 4'h0;
            else if (q_ff.rslot == 4'hF && q_ff.ones != 4'hF)
                nxt_q.ones = q_ff.ones + 4'h1;
            if (rx_bit && q_ff.ones + 4'h1 == (nine ? `AUSU_IDLE9 : `AUSU_IDLE8) && q_ff.rslot == 4'hF)
                nxt_q.ssc[`AUSU_SSC_RAF_BIT] = 1'b0;
            nxt_q.rslot = q_ff.rslot + 4'h1;
            case (q_ff.rst_)
                ausu_pkg::RX_SEARCH:
                begin
                    if (!rx_bit)
                    begin
                        nxt_q.ssc[`AUSU_SSC_RAF_BIT] = 1'b1;
                        nxt_q.rst_ = ausu_pkg::RX_SHIFT;
                        nxt_q.rslot = 4'h1;
                        nxt_q.rbits = nine ? 4'hA : 4'h9;
                    end
                end
                ausu_pkg::RX_SHIFT:
                begin
                    if (q_ff.rslot == 4'h8)
                    begin
                        nxt_q.rsh = rcv;
                        nxt_q.rbits = q_ff.rbits - 4'h1;
                        if (q_ff.rbits == 4'h0)
                            nxt_q.rst_ = ausu_pkg::RX_DONE;
                    end
                end
                ausu_pkg::RX_DONE:
                begin
                    nxt_q.rxbuf = nine ? q_ff.rsh[8:0] : {q_ff.rxbuf[8], q_ff.rsh[8:1]};
                    nxt_q.rst_ = ausu_pkg::RX_SEARCH;
                end
                default: nxt_q.rst_ = ausu_pkg::RX_SEARCH;
            endcase
        end
        if (!rstn)
        begin
            nxt_q = '0;
            nxt_q.ssc = `AUSU_SSC_RST;
            nxt_q.baud = `AUSU_BAUD_RST;
            nxt_q.cr1 = `AUSU_CR1_RST;
            nxt_q.tbit = 1'b1;
            nxt_q.txd_o = 1'b1;
            nxt_q.txd_oe = 1'b1;
            nxt_q.ones = 4'h0;
        end
    end

    always_ff @(posedge clk)
    begin
        q_ff <= nxt_q;
    end

    assign prdata = q_ff.prdata;
    assign pready = q_ff.pready;
    assign pslverr = q_ff.pslverr;
    assign txd_o = q_ff.txd_o;
    assign txd_oe = q_ff.txd_oe;
endmodule

// ==== ausu_assertions.sv ====
`timescale 1ns/10ps
`include "ausu_regs.svh"
module ausu_checker #(
    parameter int BAUD_W = 13
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // line
    input wire logic rxd_i,
    input wire logic txd_i,
    input wire logic txd_o,
    input wire logic txd_oe
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    wire logic wr_done;
    wire logic rd_done;
    assign wr_done = psel && penable && pwrite && pready;
    assign rd_done = psel && penable && !pwrite && pready;
    property p_reset_idle;
        $rose(rstn) |-> txd_o && txd_oe && !pready && !pslverr;
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("outputs not idle after reset");
    property p_answer;
        psel && penable && !pready |=> pready;
    endproperty
    a_answer: assert property (p_answer) else $error("no answer one cycle into access");
    property p_pulse;
        pready |=> !pready;
    endproperty
    a_pulse: assert property (p_pulse) else $error("ready stands over one cycle");
    property p_err_data;
        pslverr |-> pready && prdata == 32'h00000000;
    endproperty
    a_err_data: assert property (p_err_data) else $error("error without ready or with data");
    property p_err_map;
        pready && paddr[1:0] == 2'h0 |-> pslverr == (paddr > `AUSU_OFF_IRCFG);
    endproperty
    a_err_map: assert property (p_err_map) else $error("error flag wrong for address");
    property p_upper;
        pready |-> prdata[31:8] == 24'h000000;
    endproperty
    a_upper: assert property (p_upper) else $error("upper read lanes not zero");
    property p_ssc_gap;
        rd_done && paddr == `AUSU_OFF_SSC |-> prdata[6:5] == 2'h0;
    endproperty
    a_ssc_gap: assert property (p_ssc_gap) else $error("unused status bits set");
    property p_dhi_gap;
        rd_done && paddr == `AUSU_OFF_DHI |-> prdata[5:0] == 6'h00;
    endproperty
    a_dhi_gap: assert property (p_dhi_gap) else $error("unused data high bits set");
    property p_dir;
        $changed(txd_oe) |-> $past(wr_done) || $past(wr_done, 2) || $past(wr_done, 3);
    endproperty
    a_dir: assert property (p_dir) else $error("pin direction moved without write");
    c_tx_write: cover property (wr_done && paddr == `AUSU_OFF_DLO);
    c_raf_read: cover property (rd_done && paddr == `AUSU_OFF_SSC && prdata[0]);
    c_err: cover property (pslverr);
    c_oe_low: cover property (!txd_oe);
endmodule
bind ausu_top ausu_checker #(.BAUD_W(BAUD_W)) chk_u (.clk(clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxd_i(rxd_i), .txd_i(txd_i), .txd_o(txd_o), .txd_oe(txd_oe));

// ==== ausu_remote.sv ====
`timescale 1ns/10ps
module ausu_remote #(
    parameter int BIT_CYC = 64
) (
    // clock
    input wire logic clk,
    // line
    input wire logic txd,
    output logic rxd
);
    initial rxd = 1'b1;
    task automatic rest(input logic inv);
        rxd <= ~inv;
    endtask
    // start, data lsb first, stop
    task automatic send(input logic [8:0] d, input int n, input logic inv);
        logic b;
        for (int i = 0; i < n + 2; i++)
        begin
            b = (i == 0) ? 1'b0 : (i == n + 1) ? 1'b1 : d[i - 1];
            rxd <= b ^ inv;
            repeat (BIT_CYC) @(posedge clk);
        end
        rxd <= ~inv;
    endtask
    task automatic recv(output logic [8:0] d, input int n, input logic inv);
        int t;
        d = 9'h000;
        t = 0;
        while (txd !== inv && t < 5000)
        begin
            @(posedge clk);
            t++;
        end
        repeat (BIT_CYC / 2) @(posedge clk);
        for (int i = 0; i < n; i++)
        begin
            repeat (BIT_CYC) @(posedge clk);
            d[i] = txd ^ inv;
        end
        repeat (BIT_CYC) @(posedge clk);
    endtask
endmodule

// ==== testbench.sv ====
`timescale 1ns/10ps
`include "ausu_regs.svh"
module testbench;
    localparam int IR_DIV = 54;
    localparam int BIT4 = 32 * (4 / 2);
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic rx_line;
    logic txd_o;
    logic txd_oe;
    logic txd_pin;
    int miscompares = 0;
    int n_checks = 0;
    int seed;
    assign txd_pin = txd_oe ? txd_o : rx_line;
    always #5 clk = ~clk;
    ausu_top dut_u (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rxd_i(rx_line), .txd_i(txd_pin), .txd_o(txd_o), .txd_oe(txd_oe));
    ausu_remote #(.BIT_CYC(BIT4)) remote_u (.clk(clk), .txd(txd_pin), .rxd(rx_line));
    function automatic int ir_cycles(input int k);
        int f[4] = '{6, 2, 1, 8};
        return f[k] * (IR_DIV / 2);
    endfunction
    task automatic complete_run;
        if (miscompares == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] wd,
        output logic [7:0] rd, output logic err);
        int t;
        t = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h000000, wd};
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && t < 100)
        begin
            @(posedge clk);
            t++;
        end
        if (t >= 100)
            miscompares++;
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] v);
        logic [7:0] d;
        logic e;
        apb(1'b1, a, v, d, e);
    endtask
    task automatic rchk(input string n, input logic [11:0] a, input logic [7:0] m, input logic [7:0] x);
        logic [7:0] d;
        logic e;
        apb(1'b0, a, 8'h00, d, e);
        chk(n, 16'(x), 16'(d & m));
    endtask
    task automatic level_run(input logic lvl, output int w);
        int t;
        t = 0;
        w = 0;
        while (txd_o !== lvl && t < 20000)
        begin
            @(posedge clk);
            t++;
        end
        while (txd_o === lvl && w < 2000)
        begin
            @(posedge clk);
            w++;
        end
    endtask
    initial
    begin
        repeat (100000) @(posedge clk);
        miscompares++;
        complete_run;
    end
    initial
    begin
        logic [7:0] v;
        logic [8:0] q;
        logic e;
        int w;
        seed = 50750;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        rchk("baud_lo", `AUSU_OFF_MAP1, 8'hFF, 8'h04);
        rchk("ssc_rst", `AUSU_OFF_SSC, 8'hFF, 8'h00);
        rchk("dhi_rst", `AUSU_OFF_DHI, 8'hFF, 8'h00);
        apb(1'b1, 12'h01C, 8'hFF, v, e);
        chk("unmapped", 16'h0001, 16'(e));
        for (int i = 0; i < 3; i++)
        begin
            v = 8'($random(seed));
            wr(`AUSU_OFF_SSC, v);
            rchk("ssc_rw", `AUSU_OFF_SSC, 8'hFE, v & `AUSU_SSC_WMASK);
        end
        wr(`AUSU_OFF_SSC, 8'h80);
        repeat (1200) @(posedge clk);
        rchk("alt_status", `AUSU_OFF_MAP0, 8'hFF, 8'h00);
        wr(`AUSU_OFF_MAP1, 8'h5A);
        wr(`AUSU_OFF_SSC, 8'h00);
        rchk("baud_hidden", `AUSU_OFF_MAP1, 8'hFF, 8'h04);
        for (int p = 0; p < 2; p++)
        begin
            v = 8'($random(seed));
            wr(`AUSU_OFF_SSC, p ? 8'h10 : 8'h00);
            repeat (4) @(posedge clk);
            wr(`AUSU_OFF_DLO, v);
            remote_u.recv(q, 8, p[0]);
            chk("tx_byte", 16'(v), 16'(q[7:0]));
        end
        wr(`AUSU_OFF_SSC, 8'h00);
        wr(`AUSU_OFF_MAP2, 8'h10);
        wr(`AUSU_OFF_DHI, 8'h40);
        for (int i = 0; i < 2; i++)
        begin
            v = 8'($random(seed));
            wr(`AUSU_OFF_DLO, v);
            remote_u.recv(q, 9, 1'b0);
            chk("tx_nine", 16'({1'b1, v}), 16'(q));
        end
        v = 8'($random(seed));
        fork
            remote_u.send({1'b1, v}, 9, 1'b0);
            begin
                repeat (8) @(posedge clk);
                rchk("raf_set", `AUSU_OFF_SSC, 8'h01, 8'h01);
            end
        join
        repeat (800) @(posedge clk);
        rchk("raf_clr", `AUSU_OFF_SSC, 8'h01, 8'h00);
        rchk("rx_byte", `AUSU_OFF_DLO, 8'hFF, v);
        wr(`AUSU_OFF_DHI, 8'h00);
        rchk("rx_nine", `AUSU_OFF_DHI, 8'hC0, 8'h80);
        wr(`AUSU_OFF_SSC, 8'h08);
        remote_u.rest(1'b1);
        repeat (1500) @(posedge clk);
        v = 8'($random(seed));
        remote_u.send({1'b0, v}, 9, 1'b1);
        repeat (100) @(posedge clk);
        rchk("rx_inv", `AUSU_OFF_DLO, 8'hFF, v);
        wr(`AUSU_OFF_DHI, 8'hC0);
        rchk("rx_nine_ro", `AUSU_OFF_DHI, 8'hC0, 8'h40);
        wr(`AUSU_OFF_MAP2, 8'h30);
        repeat (3) @(posedge clk);
        chk("oe_in", 16'h0000, 16'(txd_oe));
        wr(`AUSU_OFF_SSC, 8'h0A);
        repeat (3) @(posedge clk);
        chk("oe_out", 16'h0001, 16'(txd_oe));
        wr(`AUSU_OFF_MAP2, 8'h00);
        remote_u.rest(1'b0);
        for (int b = 0; b < 2; b++)
        begin
            wr(`AUSU_OFF_SSC, b ? 8'h04 : 8'h00);
            wr(`AUSU_OFF_IRCFG, 8'h08);
            level_run(1'b0, w);
            chk("break_len", 16'(b ? 13 * BIT4 : 10 * BIT4), 16'(w));
            repeat (200) @(posedge clk);
        end
        wr(`AUSU_OFF_MAP1, 8'(IR_DIV));
        for (int k = 0; k < 5; k++)
        begin
            wr(`AUSU_OFF_SSC, k == 4 ? 8'h10 : 8'h00);
            wr(`AUSU_OFF_IRCFG, 8'(4 + k % 4));
            repeat (900) @(posedge clk);
            chk("ir_idle", 16'(k == 4), 16'(txd_o));
            wr(`AUSU_OFF_DLO, 8'hFF);
            level_run(k != 4, w);
            chk("ir_width", 16'(ir_cycles(k % 4)), 16'(w));
            repeat (9000) @(posedge clk);
        end
        complete_run;
    end
endmodule
